// ===== dcx_map.vh
// dcx_map.vh: offsets, field positions, reset values and codes for the
// comparator C extension and trace fifo extension block.
// assumes inclusion by bare name from the block's design files.
`ifndef DCX_MAP_VH
`define DCX_MAP_VH

// ****************************************
// register offsets (byte addresses, 8-bit data)
// ****************************************
`define DCX_ADDR_W 4
`define DCX_OFS_CCX 4'h000A
`define DCX_OFS_FX 4'h000B
`define DCX_OFS_CTL 4'h000C
`define DCX_OFS_TRG 4'h000D
`define DCX_OFS_STAT 4'h000E

// ****************************************
// comparator C extension fields
// ****************************************
`define DCX_CCX_DIR_EN 7
`define DCX_CCX_DIR_VAL 6
`define DCX_CCX_PAGE_QUALIFY_SELECT 5
`define DCX_CCX_B16 0
`define DCX_CCX_MASK 8'h00E1
`define DCX_CCX_RST 8'h0000

// ****************************************
// fifo extension fields
// ****************************************
`define DCX_FX_PAGED_ACCESS_FLAG 7
`define DCX_FX_B16 0
`define DCX_FX_RST 8'h0000

// ****************************************
// control and trigger fields
// ****************************************
`define DCX_CTL_EN 7
`define DCX_CTL_LOOP 0
`define DCX_CTL_MASK 8'h0081
`define DCX_CTL_RST 8'h0000
`define DCX_TRG_BEGIN 6
`define DCX_TRG_RST 8'h0040

// ****************************************
// address geometry
// ****************************************
`define DCX_CA_W 17
`define DCX_PG_W 3
`define DCX_OFF_W 14

`endif

// ===== dcx_sync2.v
// dcx_sync2.v: two flip-flop synchroniser for one level.
// assumes the input is asynchronous to CLK.
`timescale 1ns/1ps
module dcx_sync2 (
	input wire clk,
	input wire rst_n,
	input wire ce,
	input wire d,
	output reg q
);
	reg meta_r;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			q <= 1'b0;
		end else if (ce) begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // dcx_sync2

// ===== dcx_addr_match.v
// dcx_addr_match.v: forms the 17-bit core address and compares it.
// assumes all inputs are on the same clock; purely combinational.
`timescale 1ns/1ps
`include "dcx_map.vh"
module dcx_addr_match (
	input wire paged,
	input wire [`DCX_PG_W-1:0] page,
	input wire [15:0] cpu_addr,
	input wire lin_b16,
	input wire [`DCX_CA_W-1:0] cmp_addr,
	output wire [`DCX_CA_W-1:0] core_addr,
	output wire equal
);
	// paged: page in the top three bits, offset below; else bit 16 from linear pointer
	assign core_addr = paged ? {page, cpu_addr[`DCX_OFF_W-1:0]} : {lin_b16, cpu_addr};
	assign equal = (core_addr == cmp_addr);
endmodule // dcx_addr_match

// ===== dcx_top.v
// dcx_top.v: comparator C qualification and trace fifo extension register.
// assumes core bus signals share CLK; the secure strap is a pin and is
// synchronised; the fifo itself lives outside and only signals each head advance.
// Overview of operation
// - direction-enable set means bus direction takes part in a comparator C match.
// - direction value 0 matches writes, 1 matches reads, ignored when direction is off.
// - page-select 1 matches only paged accesses, comparing page bits over offset 13..0.
// - page-select 0 matches only unpaged accesses with a plain or linear 17-bit address.
// - core address bit 16 must equal the stored bit-16 compare value.
// - an end-trace reset with module enabled and end trigger keeps both extension registers.
// - the fifo extension register is read-only at 0x0B, bits 6..1 zero, cleared on other resets.
// - fifo extension bit 7 shows whether the current fifo word came from a paged access.
// - that indicator is 0 for event-only words and unpaged addresses.
// - that indicator is 1 for a paged flash address of page over offset 13..0.
// - fifo extension bit 0 presents bit 16 of the word's core address.
// - module enable turns the block on and is forced low while the device is secured.
// - the begin/end trigger bit chooses whether a trigger starts or ends storage.
// - in loop capture a change of flow that misses comparator C is stored to fifo and comparator C.
`timescale 1ns/1ps
`include "dcx_map.vh"
module dcx_top #(
	parameter FIFO_DEPTH = 8,
	parameter PTR_W = 3
) (
	input wire CLK,
	input wire RSTN,
	input wire CE,
	input wire END_RUN_RESET,
	input wire SECURE_PIN,
	input wire [`DCX_ADDR_W-1:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [7:0] REG_RDATA,
	input wire BUS_VALID,
	input wire BUS_READ,
	input wire [15:0] BUS_ADDR,
	input wire BUS_LIN_B16,
	input wire PAGED_ACCESS_FLAG,
	input wire [`DCX_PG_W-1:0] BUS_PAGE,
	input wire [`DCX_CA_W-1:0] CMP_C_ADDR,
	input wire CHANGE_OF_FLOW,
	input wire FIFO_STORE,
	input wire FIFO_EVENT_ONLY,
	input wire FIFO_ADVANCE,
	output reg CMP_C_MATCH,
	output reg FIFO_WR,
	output reg [`DCX_CA_W-1:0] FIFO_WORD,
	output reg CMP_C_LOAD,
	output reg [`DCX_CA_W-1:0] CMP_C_LOAD_ADDR,
	output reg DEBUG_MODULE_ENABLE,
	output reg TRIGGER_BEGIN
);
	// ****************************************
	// registers and wires
	// ****************************************
	reg [7:0] ccx_r;
	reg [7:0] fx_r;
	reg [7:0] ctl_r;
	reg [7:0] trg_r;
	reg [FIFO_DEPTH-1:0] ext_pp_r;
	reg [FIFO_DEPTH-1:0] ext_b16_r;
	reg [PTR_W-1:0] wptr_r;
	reg [PTR_W-1:0] rptr_r;
	reg [PTR_W:0] count_r;
	reg [7:0] rdata_nxt;
	wire secure_s;
	wire [`DCX_CA_W-1:0] core_addr;
	wire addr_eq;
	wire dir_ok;
	wire page_ok;
	wire b16_ok;
	wire match_c;
	wire keep;
	wire loop_mode;
	wire loop_hit;
	wire push;
	wire reload;
	wire pop;
	wire ent_pp;
	wire ent_b16;
	wire [PTR_W-1:0] head;

	dcx_sync2 u_sec (
		.clk(CLK),
		.rst_n(RSTN),
		.ce(CE),
		.d(SECURE_PIN),
		.q(secure_s)
	);

	dcx_addr_match u_match (
		.paged(PAGED_ACCESS_FLAG),
		.page(BUS_PAGE),
		.cpu_addr(BUS_ADDR),
		.lin_b16(BUS_LIN_B16),
		.cmp_addr(CMP_C_ADDR),
		.core_addr(core_addr),
		.equal(addr_eq)
	);

	// ****************************************
	// comparator C qualification
	// ****************************************
	assign dir_ok = ~ccx_r[`DCX_CCX_DIR_EN] |
		(BUS_READ == ccx_r[`DCX_CCX_DIR_VAL]);
	assign page_ok = (PAGED_ACCESS_FLAG == ccx_r[`DCX_CCX_PAGE_QUALIFY_SELECT]);
	// bit 16 of the stored compare lives in the extension, not in the low bytes
	assign b16_ok = (core_addr[`DCX_CA_W-1] == ccx_r[`DCX_CCX_B16]);
	// bit 16 is judged by b16_ok, so only the lower sixteen bits are compared here
	assign match_c = BUS_VALID & ctl_r[`DCX_CTL_EN] & dir_ok & page_ok & b16_ok &
		(core_addr[`DCX_CA_W-2:0] == CMP_C_ADDR[`DCX_CA_W-2:0]);

	// ****************************************
	// loop capture and fifo push
	// ****************************************
	assign loop_mode = ctl_r[`DCX_CTL_LOOP];
	// a loop hit overrides the capture so repeated loops do not flood the fifo
	assign loop_hit = loop_mode & CHANGE_OF_FLOW & ~FIFO_EVENT_ONLY & addr_eq &
		(PAGED_ACCESS_FLAG == ccx_r[`DCX_CCX_PAGE_QUALIFY_SELECT]);
	assign push = FIFO_STORE & ctl_r[`DCX_CTL_EN] & ~loop_hit &
		(count_r != FIFO_DEPTH[PTR_W:0]);
	assign pop = FIFO_ADVANCE & (count_r != {(PTR_W+1){1'b0}});
	// reload only with a real push, so comparator C never holds a word the fifo dropped
	assign reload = push & loop_mode & CHANGE_OF_FLOW & ~FIFO_EVENT_ONLY;
	assign ent_pp = FIFO_EVENT_ONLY ? 1'b0 : PAGED_ACCESS_FLAG;
	assign ent_b16 = FIFO_EVENT_ONLY ? 1'b0 : core_addr[`DCX_CA_W-1];
	assign head = pop ? (rptr_r + {{(PTR_W-1){1'b0}}, 1'b1}) : rptr_r;
	// end-trace reset with module on and end trigger keeps state
	assign keep = END_RUN_RESET & ctl_r[`DCX_CTL_EN] & ~trg_r[`DCX_TRG_BEGIN];

	// ****************************************
	// control registers
	// ****************************************
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ccx_r <= `DCX_CCX_RST;
			ctl_r <= `DCX_CTL_RST;
			trg_r <= `DCX_TRG_RST;
		end else if (CE) begin
			if (END_RUN_RESET) begin
				if (!keep) begin
					ccx_r <= `DCX_CCX_RST;
					ctl_r <= `DCX_CTL_RST;
					trg_r <= `DCX_TRG_RST;
				end
			end else begin
				if (secure_s)
					ctl_r[`DCX_CTL_EN] <= 1'b0;
				if (REG_WR && REG_ADDR == `DCX_OFS_CCX)
					ccx_r <= REG_WDATA & `DCX_CCX_MASK;
				else if (reload) begin
					ccx_r[`DCX_CCX_PAGE_QUALIFY_SELECT] <= PAGED_ACCESS_FLAG;
					ccx_r[`DCX_CCX_B16] <= core_addr[`DCX_CA_W-1];
				end
				if (REG_WR && REG_ADDR == `DCX_OFS_CTL)
					ctl_r <= REG_WDATA & `DCX_CTL_MASK &
						{~secure_s, 7'h7F};
				if (REG_WR && REG_ADDR == `DCX_OFS_TRG)
					trg_r <= REG_WDATA;
			end
		end
	end

	// ****************************************
	// fifo extension store and head tracking
	// ****************************************
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ext_pp_r <= {FIFO_DEPTH{1'b0}};
			ext_b16_r <= {FIFO_DEPTH{1'b0}};
			wptr_r <= {PTR_W{1'b0}};
			rptr_r <= {PTR_W{1'b0}};
			count_r <= {(PTR_W+1){1'b0}};
			fx_r <= `DCX_FX_RST;
		end else if (CE) begin
			if (END_RUN_RESET) begin
				if (!keep) begin
					wptr_r <= {PTR_W{1'b0}};
					rptr_r <= {PTR_W{1'b0}};
					count_r <= {(PTR_W+1){1'b0}};
					fx_r <= `DCX_FX_RST;
				end
			end else begin
				if (push) begin
					ext_pp_r[wptr_r] <= ent_pp;
					ext_b16_r[wptr_r] <= ent_b16;
					wptr_r <= wptr_r + {{(PTR_W-1){1'b0}}, 1'b1};
				end
				if (pop)
					rptr_r <= head;
				if (push && !pop)
					count_r <= count_r + {{PTR_W{1'b0}}, 1'b1};
				else if (pop && !push)
					count_r <= count_r - {{PTR_W{1'b0}}, 1'b1};
				// bits 6..1 held at zero
				if (count_r == {(PTR_W+1){1'b0}} && push) begin
					fx_r <= {ent_pp, 6'h00, ent_b16};
				end else if (count_r == {{PTR_W{1'b0}}, 1'b1} && pop && !push) begin
					fx_r <= `DCX_FX_RST;
				end else if (pop && count_r == {{PTR_W{1'b0}}, 1'b1} && push) begin
					fx_r <= {ent_pp, 6'h00, ent_b16};
				end else if (pop) begin
					fx_r <= {ext_pp_r[head], 6'h00, ext_b16_r[head]};
				end
			end
		end
	end

	// ****************************************
	// register read port
	// ****************************************
	always @* begin
		rdata_nxt = 8'h0000;
		case (REG_ADDR)
			`DCX_OFS_CCX: rdata_nxt = ccx_r;
			`DCX_OFS_FX: rdata_nxt = fx_r;
			`DCX_OFS_CTL: rdata_nxt = ctl_r;
			`DCX_OFS_TRG: rdata_nxt = trg_r;
			`DCX_OFS_STAT: rdata_nxt = {{(7-PTR_W){1'b0}}, count_r};
			default: rdata_nxt = 8'h0000;
		endcase
	end

	// ****************************************
	// registered outputs
	// ****************************************
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			REG_RDATA <= 8'h0000;
			CMP_C_MATCH <= 1'b0;
			FIFO_WR <= 1'b0;
			FIFO_WORD <= {`DCX_CA_W{1'b0}};
			CMP_C_LOAD <= 1'b0;
			CMP_C_LOAD_ADDR <= {`DCX_CA_W{1'b0}};
			DEBUG_MODULE_ENABLE <= 1'b0;
			TRIGGER_BEGIN <= 1'b1;
		end else if (CE) begin
			REG_RDATA <= REG_RD ? rdata_nxt : 8'h0000;
			CMP_C_MATCH <= match_c & ~END_RUN_RESET;
			FIFO_WR <= push & ~END_RUN_RESET;
			FIFO_WORD <= FIFO_EVENT_ONLY ? {`DCX_CA_W{1'b0}} : core_addr;
			CMP_C_LOAD <= reload & ~END_RUN_RESET;
			CMP_C_LOAD_ADDR <= core_addr;
			DEBUG_MODULE_ENABLE <= ctl_r[`DCX_CTL_EN] & ~secure_s;
			TRIGGER_BEGIN <= trg_r[`DCX_TRG_BEGIN];
		end
	end
endmodule // dcx_top

// ===== dcx_top_props.sv
// dcx_top_props.sv: port checker for dcx_top.
// assumes one clock CLK and RSTN low while in reset.
`timescale 1ns/1ps
module dcx_top_props (
	input wire CLK,
	input wire RSTN,
	input wire CE,
	input wire END_RUN_RESET,
	input wire SECURE_PIN,
	input wire [3:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	input wire [7:0] REG_RDATA,
	input wire BUS_VALID,
	input wire BUS_READ,
	input wire BUS_LIN_B16,
	input wire PAGED_ACCESS_FLAG,
	input wire [2:0] BUS_PAGE,
	input wire CMP_C_MATCH,
	input wire FIFO_WR,
	input wire [16:0] FIFO_WORD,
	input wire CMP_C_LOAD,
	input wire [16:0] CMP_C_LOAD_ADDR,
	input wire DEBUG_MODULE_ENABLE,
	input wire TRIGGER_BEGIN
);
// ****
// shadow of the extension register
// ****
// write-only tracking; end-run clears are not mirrored
reg [7:0] ccx_r;
wire b16 = PAGED_ACCESS_FLAG ? BUS_PAGE[2] : BUS_LIN_B16;
always @(posedge CLK or negedge RSTN) begin
	if (!RSTN)
		ccx_r <= 8'h0000;
	else if (CE && REG_WR && REG_ADDR == 4'hA)
		ccx_r <= REG_WDATA & 8'h00E1;
end
default clocking @(posedge CLK); endclocking
default disable iff (!RSTN);
fx_zero_bits_a:
	assert property ($past(REG_RD && REG_ADDR == 4'hB) |-> REG_RDATA[6:1] == 6'h00) else $error("fx gap");
dir_qualify_a:
	assert property (CMP_C_MATCH && $past(ccx_r[7]) |-> $past(BUS_READ) == $past(ccx_r[6]))
		else $error("direction");
page_qualify_a:
	assert property (CMP_C_MATCH |-> $past(PAGED_ACCESS_FLAG) == $past(ccx_r[5])) else $error("page");
bit16_a:
	assert property (CMP_C_MATCH |-> $past(b16) == $past(ccx_r[0])) else $error("bit 16");
match_cause_a:
	assert property (CMP_C_MATCH |-> $past(BUS_VALID && DEBUG_MODULE_ENABLE)) else $error("cause");
secure_off_a:
	assert property (SECURE_PIN [*4] |=> !DEBUG_MODULE_ENABLE) else $error("secured");
end_keep_a:
	assert property (END_RUN_RESET && DEBUG_MODULE_ENABLE && !TRIGGER_BEGIN && !SECURE_PIN
		|=> DEBUG_MODULE_ENABLE && !TRIGGER_BEGIN) else $error("keep");
end_clear_a:
	assert property (END_RUN_RESET && !(DEBUG_MODULE_ENABLE && !TRIGGER_BEGIN)
		|=> ##1 (!DEBUG_MODULE_ENABLE && TRIGGER_BEGIN)) else $error("clear");
load_store_a:
	assert property (CMP_C_LOAD |-> FIFO_WR && CMP_C_LOAD_ADDR == FIFO_WORD) else $error("load");
cover property (CMP_C_MATCH);
cover property (CMP_C_LOAD);
cover property (END_RUN_RESET && !TRIGGER_BEGIN);
endmodule // dcx_top_props
bind dcx_top dcx_top_props u_dcx_top_props (.*);

// ===== dcx_core_mdl.sv
// dcx_core_mdl.sv: core bus and capture side facing dcx_top.
// assumes CLK from the bench; one access per call.
`timescale 1ns/1ps
module dcx_core_mdl (
	input wire CLK,
	output reg BUS_VALID = 1'b0,
	output reg BUS_READ = 1'b0,
	output reg [15:0] BUS_ADDR = 16'h0000,
	output reg BUS_LIN_B16 = 1'b0,
	output reg PAGED_ACCESS_FLAG = 1'b0,
	output reg [2:0] BUS_PAGE = 3'h0,
	output reg CHANGE_OF_FLOW = 1'b0,
	output reg FIFO_STORE = 1'b0,
	output reg FIFO_EVENT_ONLY = 1'b0
);
task acc(input rd, pg, input [2:0] p, input [15:0] a, input lin, st, ev, change_of_flow);
	begin
		@(posedge CLK);
		BUS_VALID <= 1'b1;
		BUS_READ <= rd;
		PAGED_ACCESS_FLAG <= pg;
		BUS_PAGE <= p;
		BUS_ADDR <= a;
		BUS_LIN_B16 <= lin;
		FIFO_STORE <= st;
		FIFO_EVENT_ONLY <= ev;
		CHANGE_OF_FLOW <= change_of_flow;
		@(posedge CLK);
		// released data lines invert and the strobes drop so a stale value never looks live
		BUS_VALID <= 1'b0;
		BUS_READ <= !rd;
		PAGED_ACCESS_FLAG <= !pg;
		BUS_PAGE <= ~p;
		BUS_ADDR <= ~a;
		BUS_LIN_B16 <= !lin;
		FIFO_STORE <= 1'b0;
		FIFO_EVENT_ONLY <= !ev;
		CHANGE_OF_FLOW <= 1'b0;
	end
endtask
endmodule // dcx_core_mdl

// ===== dcx_top_tb.sv
// dcx_top_tb.sv: self-checking bench for dcx_top.
// assumes dcx_core_mdl drives the core side; CE held high except for one write in t_regs.
`timescale 1ns/1ps
module dcx_top_tb;
reg clk = 1'b0, rstn = 1'b0, erst = 1'b0, sec = 1'b0, wr_s = 1'b0, rd_s = 1'b0, adv_s = 1'b0;
reg ce = 1'b1;
reg [3:0] addr = 4'h0;
reg [7:0] wdata = 8'h0000;
reg [16:0] cmp = 17'h0_0000;
wire valid, rdb, lin, pg, change_of_flow, st, ev, match, load;
wire [15:0] baddr;
wire [2:0] page;
wire [7:0] rdata;
wire [16:0] load_addr;
wire fwr, dme, tbeg;
wire [16:0] fword;
integer fails = 0, total_checks = 0;
always #25 clk = ~clk;
dcx_top u_dcx_top (.CLK(clk), .RSTN(rstn), .CE(ce), .END_RUN_RESET(erst), .SECURE_PIN(sec),
	.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata),
	.BUS_VALID(valid), .BUS_READ(rdb), .BUS_ADDR(baddr), .BUS_LIN_B16(lin),
	.PAGED_ACCESS_FLAG(pg), .BUS_PAGE(page), .CMP_C_ADDR(cmp), .CHANGE_OF_FLOW(change_of_flow),
	.FIFO_STORE(st), .FIFO_EVENT_ONLY(ev), .FIFO_ADVANCE(adv_s), .CMP_C_MATCH(match),
	.FIFO_WR(fwr), .FIFO_WORD(fword), .CMP_C_LOAD(load), .CMP_C_LOAD_ADDR(load_addr),
	.DEBUG_MODULE_ENABLE(dme), .TRIGGER_BEGIN(tbeg));
dcx_core_mdl u_dcx_core_mdl (.CLK(clk), .BUS_VALID(valid), .BUS_READ(rdb), .BUS_ADDR(baddr),
	.BUS_LIN_B16(lin), .PAGED_ACCESS_FLAG(pg), .BUS_PAGE(page), .CHANGE_OF_FLOW(change_of_flow),
	.FIFO_STORE(st), .FIFO_EVENT_ONLY(ev));
task chk(input [16:0] got, exp);
	begin
		total_checks = total_checks + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	end
endtask
task end_of_test;
	begin
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
endtask
task wr(input [3:0] a, input [7:0] d);
	begin
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	end
endtask
task rd(input [3:0] a, input [7:0] e);
	begin
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk({9'h000, rdata}, {9'h000, e});
	end
endtask
// one-cycle pulse on the end-run reset or the fifo advance
task pulse(input which);
	begin
		@(posedge clk);
		if (which) erst <= 1'b1; else adv_s <= 1'b1;
		@(posedge clk);
		erst <= 1'b0;
		adv_s <= 1'b0;
	end
endtask
task bus(input r, p, input [2:0] pp, input [15:0] a, input l, s, e, c, m);
	begin
		u_dcx_core_mdl.acc(r, p, pp, a, l, s, e, c);
		#1 chk({16'h0000, match}, {16'h0000, m});
	end
endtask
task t_regs;
	begin
		rd(4'hB, 8'h0000);
		chk({16'h0000, tbeg}, 17'h0_0001);
		wr(4'hA, 8'h00FF);
		rd(4'hA, 8'h00E1);
		// a write while the clock enable is low must leave the register alone
		@(posedge clk) ce <= 1'b0;
		wr(4'hA, 8'h0000);
		@(posedge clk) ce <= 1'b1;
		rd(4'hA, 8'h00E1);
		wr(4'hB, 8'h00FF);
		rd(4'hB, 8'h0000);
		rd(4'h3, 8'h0000);
		wr(4'hC, 8'h0080);
		rd(4'hC, 8'h0080);
		chk({16'h0000, dme}, 17'h0_0001);
	end
endtask
task t_match;
	begin
		@(posedge clk) cmp <= 17'h0_1234;
		wr(4'hA, 8'h00C0);
		bus(1, 0, 0, 16'h1234, 0, 0, 0, 0, 1);
		bus(0, 0, 0, 16'h1234, 0, 0, 0, 0, 0);
		wr(4'hA, 8'h0080);
		bus(0, 0, 0, 16'h1234, 0, 0, 0, 0, 1);
		bus(1, 0, 0, 16'h1234, 0, 0, 0, 0, 0);
		wr(4'hA, 8'h0000);
		bus(0, 0, 0, 16'h1234, 0, 0, 0, 0, 1);
		bus(0, 1, 0, 16'h1234, 0, 0, 0, 0, 0);
		bus(0, 0, 0, 16'h1234, 1, 0, 0, 0, 0);
		@(posedge clk) cmp <= 17'h1_4123;
		wr(4'hA, 8'h0021);
		bus(1, 1, 5, 16'h8123, 0, 0, 0, 0, 1);
		bus(1, 0, 5, 16'h8123, 1, 0, 0, 0, 0);
	end
endtask
task t_fifo;
	begin
		bus(0, 1, 6, 16'h0001, 0, 1, 0, 0, 0);
		bus(0, 0, 0, 16'h0001, 1, 1, 0, 0, 0);
		bus(0, 1, 6, 16'h0001, 0, 1, 1, 0, 0);
		rd(4'hB, 8'h0081);
		pulse(0);
		rd(4'hB, 8'h0001);
		pulse(0);
		rd(4'hB, 8'h0000);
		pulse(0);
		rd(4'hB, 8'h0000);
	end
endtask
task t_loop;
	begin
		wr(4'hC, 8'h0081);
		bus(1, 1, 5, 16'h0124, 0, 1, 0, 1, 0);
		chk({16'h0000, load}, 17'h0_0001);
		chk(load_addr, 17'h1_4124);
		chk(fword, 17'h1_4124);
		chk({16'h0000, fwr}, 17'h0_0001);
		bus(1, 1, 5, 16'h0123, 0, 1, 0, 1, 1);
		chk({16'h0000, load}, 17'h0_0000);
		chk({16'h0000, fwr}, 17'h0_0000);
	end
endtask
task t_end;
	begin
		wr(4'hD, 8'h0000);
		pulse(1);
		#1 chk({16'h0000, tbeg}, 17'h0_0000);
		rd(4'hA, 8'h0021);
		rd(4'hB, 8'h0081);
		rd(4'hC, 8'h0081);
		wr(4'hD, 8'h0040);
		pulse(1);
		rd(4'hA, 8'h0000);
		rd(4'hB, 8'h0000);
		wr(4'hC, 8'h0080);
		@(posedge clk) sec <= 1'b1;
		repeat (5) @(posedge clk);
		rd(4'hC, 8'h0000);
		wr(4'hC, 8'h0080);
		rd(4'hC, 8'h0000);
		chk({16'h0000, dme}, 17'h0_0000);
		chk({16'h0000, tbeg}, 17'h0_0001);
	end
endtask
initial begin
	#1000000;
	fails = fails + 1;
	end_of_test;
end
initial begin
	repeat (20) @(posedge clk);
	rstn <= 1'b1;
	t_regs;
	t_match;
	t_fifo;
	t_loop;
	t_end;
	end_of_test;
end
endmodule // dcx_top_tb
